// File: pkg/bbd_regs.svh
// Opcode, field and timing constants of the bit and branch decoder
`ifndef BBD_REGS_SVH
`define BBD_REGS_SVH
// Behaviour
// (RULE1) Opcode 82 ANDs addressed bit into carry; two bytes, two cycles.
// (RULE2) Opcode B0 ANDs inverted bit into carry, bit kept; two bytes, two cycles.
// (RULE3) Opcode 72 ORs addressed bit into carry; two bytes, two cycles.
// (RULE4) Opcode A0 ORs inverted bit into carry, bit kept; two bytes, two cycles.
// (RULE5) Opcode A2 copies addressed bit into carry; two bytes, one cycle.
// (RULE6) Opcode 92 writes carry into addressed bit; two bytes, two cycles.
// (RULE7) Bit operand is one direct bit; C2, D2, B2 clear, set, invert it.
// (RULE8) Eleven-bit target replaces low bits, staying in the next byte's page.
// (RULE9) Low nibble 1: odd high nibble calls, even jumps; two bytes, two cycles.
// (RULE10) Opcodes 12 and 02 call and jump to sixteen-bit target; three bytes.
// (RULE11) Relative offset is signed byte added to next instruction address.
// (RULE12) Opcode 80 jumps by relative offset; two bytes, two cycles.
// (RULE13) Opcode 73 jumps to accumulator plus data pointer; one byte, two cycles.
// (RULE14) Opcode 60 branches on zero accumulator, 70 on nonzero.
// (RULE15) Opcode 40 branches on carry set, 50 on carry clear.
// (RULE16) Opcode 20 branches on bit set, 30 on bit clear; three bytes.
// (RULE17) Opcode 10 branches on bit set and clears that bit.
// (RULE18) Compare opcodes B4 to BF branch when operands differ; three bytes.
// (RULE19) D8 to DF decrement working register, branch if result nonzero.
// (RULE20) Opcode D5 decrements direct byte, branches if result nonzero.
// (RULE21) Low nibbles 8 to F select working register 0 to 7.
// (RULE22) Indirect operand uses working register 0 or 1 by low opcode bit.
// (RULE23) Direct byte reaches 128 RAM locations or special function registers.
// (RULE24) Sixteen-bit immediate is taken from second and third bytes.
// (RULE25) Page target bits 10 to 8 come from opcode bits 7 to 5.
// (RULE26) Calls push return address low byte first; returns pop it back.
// (RULE27) Opcode 00 does nothing; C3, D3, B3 clear, set, invert carry.
`define OP_NO_OPERATION 8'h00
`define OP_AND_C 8'h82
`define OP_ANDN_C 8'hb0
`define OP_OR_C 8'h72
`define OP_ORN_C 8'ha0
`define OP_MOV_CB 8'ha2
`define OP_MOV_BC 8'h92
`define OP_CLR_BIT 8'hc2
`define OP_SET_BIT 8'hd2
`define OP_INV_BIT 8'hb2
`define OP_CLR_C 8'hc3
`define OP_SET_C 8'hd3
`define OP_INV_C 8'hb3
`define OP_LONG_CALL 8'h12
`define OP_LONG_JUMP 8'h02
`define OP_SUB_RET 8'h22
`define OP_INT_RET 8'h32
`define OP_SHORT_JUMP 8'h80
`define OP_IND_JUMP 8'h73
`define OP_ACC_ZERO 8'h60
`define OP_ACC_NZ 8'h70
`define OP_CY_SET 8'h40
`define OP_CY_CLR 8'h50
`define OP_BIT_SET 8'h20
`define OP_BIT_CLR 8'h30
`define OP_BIT_SET_CLR 8'h10
`define OP_CMP_DIR 8'hb5
`define OP_CMP_IMM 8'hb4
`define OP_DEC_DIR 8'hd5
`define ABS_LO_NIB 4'h1
`define CMP_REG_NIB 4'hb
`define DEC_REG_NIB 4'hd
`define CMP_IND_PAIR 7'h5b
`define DIRECT_RAM_TOP 8'h80
`define BIT_RAM_BASE 4'h2
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define MC_ONE 2'h1
`define MC_TWO 2'h2
`define MC_CLKS_DEF 4
`endif

// File: pkg/bbd_pkg.sv
// Types shared by the bit and branch decoder
package bbd_pkg;
   typedef enum logic [5:0] {
      CL_ILLEGAL, CL_NOOP, CL_CLR_C, CL_SET_C, CL_INV_C, CL_CLR_BIT,
      CL_SET_BIT, CL_INV_BIT, CL_AND_C, CL_ANDN_C, CL_OR_C, CL_ORN_C,
      CL_MOV_CB, CL_MOV_BC, CL_ABS_CALL, CL_ABS_JUMP, CL_LONG_CALL,
      CL_LONG_JUMP, CL_SUB_RET, CL_INT_RET, CL_SHORT_JUMP, CL_IND_JUMP,
      CL_ACC_ZERO, CL_ACC_NZ, CL_CY_SET, CL_CY_CLR, CL_BIT_SET,
      CL_BIT_CLR, CL_BIT_SET_CLR, CL_CMP_DIR, CL_CMP_IMM, CL_CMP_IND,
      CL_CMP_REG, CL_DEC_REG, CL_DEC_DIR
   } bbd_cls_t;
   typedef enum logic [2:0] {
      OPK_NONE, OPK_DIRECT, OPK_REG, OPK_INDIRECT, OPK_BIT
   } bbd_opk_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FETCH = 3'h1,
      ST_EXEC = 3'h3,
      ST_STK1 = 3'h2,
      ST_STK2 = 3'h6,
      ST_WAIT = 3'h7
   } bbd_state_t;
endpackage

// File: rtl/bbd_decoder.sv
// Bit manipulation and program control decoder with cycle timing
`include "bbd_regs.svh"
module bbd_decoder #(
   parameter int MC_CLKS = `MC_CLKS_DEF
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic [7:0] opcode_i,
   input wire logic [7:0] byte2_i,
   input wire logic [7:0] byte3_i,
   input wire logic [15:0] next_pc_i,
   input wire logic [7:0] acc_i,
   input wire logic [15:0] data_pointer_i,
   input wire logic carry_i,
   input wire logic bit_i,
   input wire logic [7:0] operand_i,
   input wire logic [7:0] stack_data_i,
   output logic busy_o,
   output logic done_o,
   output logic illegal_o,
   output logic [1:0] instr_len_o,
   output logic [1:0] mc_count_o,
   output bbd_pkg::bbd_opk_t operand_kind_o,
   output logic [7:0] operand_addr_o,
   output logic operand_sfr_o,
   output logic [2:0] bit_sel_o,
   output logic pc_load_o,
   output logic [15:0] pc_target_o,
   output logic carry_we_o,
   output logic carry_o,
   output logic bit_we_o,
   output logic bit_o,
   output logic byte_we_o,
   output logic [7:0] byte_o,
   output logic push_o,
   output logic pop_o,
   output logic [7:0] stack_byte_o,
   output logic int_done_o
);
   import bbd_pkg::*;

   bbd_state_t state;
   bbd_cls_t cls;
   bbd_cls_t next_cls;
   logic [7:0] op;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [15:0] npc;
   logic [7:0] ret_hi;
   logic [7:0] cnt;
   logic [7:0] total;
   logic [1:0] next_len;
   logic [1:0] next_mc;
   logic [7:0] rel;
   logic [15:0] rel_target;
   logic [7:0] dec_val;
   logic is_call;
   logic is_ret;
   logic take;

   // Opcode to class; pattern groups first, then exact codes
   always_comb begin
      next_cls = CL_ILLEGAL;
      if (opcode_i[3:0] == `ABS_LO_NIB) begin
         next_cls = opcode_i[4] ? CL_ABS_CALL : CL_ABS_JUMP; // RULE9
      end else if (opcode_i[7:4] == `CMP_REG_NIB && opcode_i[3]) begin
         next_cls = CL_CMP_REG; // RULE21
      end else if (opcode_i[7:4] == `DEC_REG_NIB && opcode_i[3]) begin
         next_cls = CL_DEC_REG; // RULE21
      end else if (opcode_i[7:1] == `CMP_IND_PAIR) begin
         next_cls = CL_CMP_IND;
      end else begin
         case (opcode_i)
            `OP_NO_OPERATION: next_cls = CL_NOOP;
            `OP_AND_C: next_cls = CL_AND_C;
            `OP_ANDN_C: next_cls = CL_ANDN_C;
            `OP_OR_C: next_cls = CL_OR_C;
            `OP_ORN_C: next_cls = CL_ORN_C;
            `OP_MOV_CB: next_cls = CL_MOV_CB;
            `OP_MOV_BC: next_cls = CL_MOV_BC;
            `OP_CLR_BIT: next_cls = CL_CLR_BIT;
            `OP_SET_BIT: next_cls = CL_SET_BIT;
            `OP_INV_BIT: next_cls = CL_INV_BIT;
            `OP_CLR_C: next_cls = CL_CLR_C;
            `OP_SET_C: next_cls = CL_SET_C;
            `OP_INV_C: next_cls = CL_INV_C;
            `OP_LONG_CALL: next_cls = CL_LONG_CALL;
            `OP_LONG_JUMP: next_cls = CL_LONG_JUMP;
            `OP_SUB_RET: next_cls = CL_SUB_RET;
            `OP_INT_RET: next_cls = CL_INT_RET;
            `OP_SHORT_JUMP: next_cls = CL_SHORT_JUMP;
            `OP_IND_JUMP: next_cls = CL_IND_JUMP;
            `OP_ACC_ZERO: next_cls = CL_ACC_ZERO;
            `OP_ACC_NZ: next_cls = CL_ACC_NZ;
            `OP_CY_SET: next_cls = CL_CY_SET;
            `OP_CY_CLR: next_cls = CL_CY_CLR;
            `OP_BIT_SET: next_cls = CL_BIT_SET;
            `OP_BIT_CLR: next_cls = CL_BIT_CLR;
            `OP_BIT_SET_CLR: next_cls = CL_BIT_SET_CLR;
            `OP_CMP_DIR: next_cls = CL_CMP_DIR;
            `OP_CMP_IMM: next_cls = CL_CMP_IMM;
            `OP_DEC_DIR: next_cls = CL_DEC_DIR;
            default: next_cls = CL_ILLEGAL;
         endcase
      end
   end

   // Byte length and machine cycles per class
   always_comb begin
      next_len = `LEN_TWO;
      next_mc = `MC_TWO;
      case (next_cls)
         CL_ILLEGAL, CL_NOOP, CL_CLR_C, CL_SET_C, CL_INV_C: begin
            next_len = `LEN_ONE; // RULE27
            next_mc = `MC_ONE;
         end
         CL_CLR_BIT, CL_SET_BIT, CL_INV_BIT, CL_MOV_CB: begin
            next_mc = `MC_ONE; // RULE5 RULE7
         end
         CL_SUB_RET, CL_INT_RET, CL_IND_JUMP: begin
            next_len = `LEN_ONE; // RULE13
         end
         CL_LONG_CALL, CL_LONG_JUMP, CL_BIT_SET, CL_BIT_CLR,
         CL_BIT_SET_CLR, CL_CMP_DIR, CL_CMP_IMM, CL_CMP_IND,
         CL_CMP_REG, CL_DEC_DIR: begin
            next_len = `LEN_THREE; // RULE10 RULE16 RULE18 RULE20
         end
         default: begin
            next_len = `LEN_TWO; // RULE1 RULE9 RULE12 RULE19
         end
      endcase
   end

   // Offset sits after any bit or data byte
   assign rel = (instr_len_o == `LEN_THREE) ? b3 : b2;
   assign rel_target = npc + {{8{rel[7]}}, rel}; // RULE11
   assign dec_val = operand_i - 8'h01;
   assign is_call = cls inside {CL_ABS_CALL, CL_LONG_CALL};
   assign is_ret = cls inside {CL_SUB_RET, CL_INT_RET};

   // Branch decision for conditional classes
   always_comb begin
      case (cls)
         CL_SHORT_JUMP: take = 1'b1; // RULE12
         CL_ACC_ZERO: take = (acc_i == 8'h00); // RULE14
         CL_ACC_NZ: take = (acc_i != 8'h00); // RULE14
         CL_CY_SET: take = carry_i; // RULE15
         CL_CY_CLR: take = !carry_i; // RULE15
         CL_BIT_SET, CL_BIT_SET_CLR: take = bit_i; // RULE16 RULE17
         CL_BIT_CLR: take = !bit_i; // RULE16
         CL_CMP_DIR: take = (acc_i != operand_i); // RULE18
         CL_CMP_IMM: take = (acc_i != b2); // RULE18
         CL_CMP_IND, CL_CMP_REG: take = (operand_i != b2); // RULE18
         CL_DEC_REG, CL_DEC_DIR: take = (dec_val != 8'h00); // RULE19 RULE20
         default: take = 1'b0;
      endcase
   end

   // Sequencer and cycle counter
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         cnt <= cnt + 8'h01;
         case (state)
            ST_IDLE: begin
               if (start_i) begin
                  state <= ST_FETCH;
                  cnt <= 8'h00;
                  busy_o <= 1'b1;
               end
            end
            ST_FETCH: state <= ST_EXEC;
            ST_EXEC: state <= (is_call || is_ret) ? ST_STK1 : ST_WAIT;
            ST_STK1: state <= ST_STK2;
            ST_STK2: state <= ST_WAIT;
            default: begin
               if (cnt >= total - 8'h01) begin
                  state <= ST_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
         endcase
      end
   end

   // Instruction capture at start
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cls <= CL_ILLEGAL;
         op <= 8'h00;
         b2 <= 8'h00;
         b3 <= 8'h00;
         npc <= 16'h0000;
         total <= 8'h00;
         instr_len_o <= `LEN_ONE;
         mc_count_o <= `MC_ONE;
         illegal_o <= 1'b0;
      end else if (state == ST_IDLE && start_i) begin
         cls <= next_cls;
         op <= opcode_i;
         b2 <= byte2_i;
         b3 <= byte3_i;
         npc <= next_pc_i;
         total <= 8'(next_mc * MC_CLKS);
         instr_len_o <= next_len;
         mc_count_o <= next_mc;
         illegal_o <= (next_cls == CL_ILLEGAL);
      end
   end

   // Operand select, loaded at the end of the fetch cycle and shown from the execute cycle onward
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         operand_kind_o <= OPK_NONE;
         operand_addr_o <= 8'h00;
         operand_sfr_o <= 1'b0;
         bit_sel_o <= 3'h0;
      end else if (state == ST_FETCH) begin
         operand_kind_o <= OPK_NONE;
         operand_addr_o <= b2;
         operand_sfr_o <= (b2 >= `DIRECT_RAM_TOP); // RULE23
         bit_sel_o <= b2[2:0];
         case (cls)
            CL_CLR_BIT, CL_SET_BIT, CL_INV_BIT, CL_AND_C, CL_ANDN_C,
            CL_OR_C, CL_ORN_C, CL_MOV_CB, CL_MOV_BC, CL_BIT_SET,
            CL_BIT_CLR, CL_BIT_SET_CLR: begin
               operand_kind_o <= OPK_BIT; // RULE7
               // Low bit space maps onto RAM bytes 20h to 2Fh
               operand_addr_o <= b2[7] ? {b2[7:3], 3'h0}
                                       : {`BIT_RAM_BASE, b2[6:3]};
            end
            CL_CMP_DIR, CL_DEC_DIR: operand_kind_o <= OPK_DIRECT;
            CL_CMP_REG, CL_DEC_REG: begin
               operand_kind_o <= OPK_REG; // RULE21
               operand_addr_o <= {5'h00, op[2:0]};
               operand_sfr_o <= 1'b0;
            end
            CL_CMP_IND: begin
               operand_kind_o <= OPK_INDIRECT; // RULE22
               operand_addr_o <= {7'h00, op[0]};
               operand_sfr_o <= 1'b0;
            end
            default: operand_kind_o <= OPK_NONE;
         endcase
      end
   end

   // Carry, bit, byte and program counter results
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pc_load_o <= 1'b0;
         pc_target_o <= 16'h0000;
         carry_we_o <= 1'b0;
         carry_o <= 1'b0;
         bit_we_o <= 1'b0;
         bit_o <= 1'b0;
         byte_we_o <= 1'b0;
         byte_o <= 8'h00;
      end else begin
         pc_load_o <= 1'b0;
         carry_we_o <= 1'b0;
         bit_we_o <= 1'b0;
         byte_we_o <= 1'b0;
         if (state == ST_EXEC) begin
            pc_load_o <= take;
            pc_target_o <= rel_target;
            case (cls)
               CL_CLR_C: begin
                  carry_we_o <= 1'b1; // RULE27
                  carry_o <= 1'b0;
               end
               CL_SET_C: begin
                  carry_we_o <= 1'b1; // RULE27
                  carry_o <= 1'b1;
               end
               CL_INV_C: begin
                  carry_we_o <= 1'b1; // RULE27
                  carry_o <= !carry_i;
               end
               CL_AND_C: begin
                  carry_we_o <= 1'b1;
                  carry_o <= carry_i & bit_i; // RULE1
               end
               CL_ANDN_C: begin
                  carry_we_o <= 1'b1;
                  carry_o <= carry_i & !bit_i; // RULE2
               end
               CL_OR_C: begin
                  carry_we_o <= 1'b1;
                  carry_o <= carry_i | bit_i; // RULE3
               end
               CL_ORN_C: begin
                  carry_we_o <= 1'b1;
                  carry_o <= carry_i | !bit_i; // RULE4
               end
               CL_MOV_CB: begin
                  carry_we_o <= 1'b1;
                  carry_o <= bit_i; // RULE5
               end
               CL_MOV_BC: begin
                  bit_we_o <= 1'b1;
                  bit_o <= carry_i; // RULE6
               end
               CL_CLR_BIT: begin
                  bit_we_o <= 1'b1; // RULE7
                  bit_o <= 1'b0;
               end
               CL_SET_BIT: begin
                  bit_we_o <= 1'b1; // RULE7
                  bit_o <= 1'b1;
               end
               CL_INV_BIT: begin
                  bit_we_o <= 1'b1; // RULE7
                  bit_o <= !bit_i;
               end
               CL_BIT_SET_CLR: begin
                  bit_we_o <= bit_i; // RULE17
                  bit_o <= 1'b0;
               end
               CL_DEC_REG, CL_DEC_DIR: begin
                  byte_we_o <= 1'b1; // RULE19 RULE20
                  byte_o <= dec_val;
               end
               CL_ABS_CALL, CL_ABS_JUMP: begin
                  pc_load_o <= 1'b1;
                  pc_target_o <= {npc[15:11], op[7:5], b2}; // RULE8 RULE25
               end
               CL_LONG_CALL, CL_LONG_JUMP: begin
                  pc_load_o <= 1'b1;
                  pc_target_o <= {b2, b3}; // RULE10 RULE24
               end
               CL_IND_JUMP: begin
                  pc_load_o <= 1'b1;
                  pc_target_o <= data_pointer_i + {8'h00, acc_i}; // RULE13
               end
               default: begin
               end
            endcase
         end else if (state == ST_STK2 && is_ret) begin
            pc_load_o <= 1'b1; // RULE26
            pc_target_o <= {ret_hi, stack_data_i};
         end
      end
   end

   // Stack traffic: push low then high, pop high then low
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         push_o <= 1'b0;
         pop_o <= 1'b0;
         stack_byte_o <= 8'h00;
         ret_hi <= 8'h00;
         int_done_o <= 1'b0;
      end else begin
         push_o <= 1'b0;
         pop_o <= 1'b0;
         int_done_o <= 1'b0;
         if (state == ST_EXEC) begin
            push_o <= is_call; // RULE26
            pop_o <= is_ret;
            stack_byte_o <= npc[7:0];
         end else if (state == ST_STK1) begin
            push_o <= is_call;
            pop_o <= is_ret;
            stack_byte_o <= npc[15:8];
            ret_hi <= stack_data_i;
         end else if (state == ST_STK2) begin
            int_done_o <= (cls == CL_INT_RET); // RULE26
         end
      end
   end

   // Cycles from the third quiet sample to done for a one-cycle opcode
   localparam int NOP_GAP = (MC_CLKS < 3) ? 1 : MC_CLKS - 2;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   and_carry_a: assert property ( // RULE1
      state == ST_EXEC && cls == CL_AND_C |=> carry_we_o &&
      carry_o == ($past(carry_i) & $past(bit_i)))
      else $error("carry AND result wrong");
   andn_carry_a: assert property ( // RULE2
      state == ST_EXEC && cls == CL_ANDN_C |=> carry_we_o && !bit_we_o &&
      carry_o == ($past(carry_i) & !$past(bit_i)))
      else $error("carry AND-inverse result wrong");
   orn_carry_a: assert property ( // RULE4
      state == ST_EXEC && cls == CL_ORN_C |=> carry_we_o && !bit_we_o &&
      carry_o == ($past(carry_i) | !$past(bit_i)))
      else $error("carry OR-inverse result wrong");
   bit_store_a: assert property ( // RULE6
      state == ST_EXEC && cls == CL_MOV_BC |=> bit_we_o && !carry_we_o &&
      bit_o == $past(carry_i))
      else $error("carry not written to bit");
   page_target_a: assert property ( // RULE8
      state == ST_EXEC && cls inside {CL_ABS_CALL, CL_ABS_JUMP} |=>
      pc_load_o && pc_target_o ==
      {$past(npc[15:11]), $past(op[7:5]), $past(b2)})
      else $error("page target wrong");
   abs_timing_a: assert property ( // RULE9
      state == ST_IDLE && start_i && opcode_i[3:0] == 4'h1 |=>
      instr_len_o == 2'h2 && mc_count_o == 2'h2 && busy_o)
      else $error("page branch length or cycles wrong");
   rel_branch_a: assert property ( // RULE11
      state == ST_EXEC && cls == CL_SHORT_JUMP |=> pc_load_o &&
      pc_target_o == $past(npc) + {{8{$past(b2[7])}}, $past(b2)})
      else $error("relative target wrong");
   dec_branch_a: assert property ( // RULE19
      state == ST_EXEC && cls == CL_DEC_REG |=> byte_we_o &&
      byte_o == $past(operand_i) - 8'h01 &&
      pc_load_o == (byte_o != 8'h00))
      else $error("decrement branch wrong");
   call_push_a: assert property ( // RULE26
      state == ST_EXEC && is_call |=> push_o &&
      stack_byte_o == $past(npc[7:0]) ##1 push_o &&
      stack_byte_o == npc[15:8] ##1 !push_o)
      else $error("return address push order wrong");
   done_time_a: assert property ( // RULE27
      state == ST_IDLE && start_i && opcode_i == `OP_NO_OPERATION |=>
      !done_o [*3] ##NOP_GAP done_o)
      else $error("one-cycle instruction timing wrong");

   call_seen_c: cover property (state == ST_EXEC && is_call);
   ret_seen_c: cover property (state == ST_STK2 && cls == CL_INT_RET);
   loop_taken_c: cover property (state == ST_EXEC && cls == CL_DEC_REG
                                 && take);
   bit_clear_c: cover property (state == ST_EXEC &&
                                cls == CL_BIT_SET_CLR && bit_i);
endmodule

// File: tb/tb_bbd_decoder.sv
// Self-checking bench for the bit and branch decoder
module tb_bbd_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import bbd_pkg::*;
   localparam int MCK = 2;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic start_i = 1'b0;
   logic [7:0] opcode_i = 8'h00;
   logic [7:0] byte2_i = 8'h00;
   logic [7:0] byte3_i = 8'h00;
   logic [15:0] next_pc_i = 16'h0000;
   logic [7:0] acc_i = 8'h00;
   logic [15:0] data_pointer_i = 16'h0000;
   logic carry_i = 1'b0;
   logic bit_i = 1'b0;
   logic [7:0] operand_i = 8'h00;
   logic [7:0] stack_data_i;
   logic busy_o, done_o, illegal_o, operand_sfr_o, pc_load_o, carry_we_o;
   logic carry_o, bit_we_o, bit_o, byte_we_o, push_o, pop_o, int_done_o;
   logic [1:0] instr_len_o, mc_count_o;
   bbd_opk_t operand_kind_o;
   logic [7:0] operand_addr_o, byte_o, stack_byte_o, yv;
   logic [2:0] bit_sel_o;
   logic [15:0] pc_target_o, tgt, pushed;
   logic cv, bv, idn;
   int npush, npop;
   int cycles = 0;
   int miscompares = 0;
   int num_checks = 0;

   bbd_decoder #(.MC_CLKS(MCK)) dut_u (
      .ref_clk_i, .srst_i, .start_i, .opcode_i, .byte2_i, .byte3_i,
      .next_pc_i, .acc_i, .data_pointer_i, .carry_i, .bit_i, .operand_i,
      .stack_data_i, .busy_o, .done_o, .illegal_o, .instr_len_o,
      .mc_count_o, .operand_kind_o, .operand_addr_o, .operand_sfr_o,
      .bit_sel_o, .pc_load_o, .pc_target_o, .carry_we_o, .carry_o,
      .bit_we_o, .bit_o, .byte_we_o, .byte_o, .push_o, .pop_o,
      .stack_byte_o, .int_done_o);

   // Stack answers high byte on the first pop, low byte on the second
   assign stack_data_i = (npop == 0) ? 8'hab : 8'hcd;

   always #5 ref_clk_i = ~ref_clk_i;

   // Captures every write strobe so the tasks can judge them afterwards
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         miscompares++;
         complete_run();
      end
      if (pc_load_o === 1'b1) tgt = pc_target_o;
      if (carry_we_o === 1'b1) cv = carry_o;
      if (bit_we_o === 1'b1) bv = bit_o;
      if (byte_we_o === 1'b1) yv = byte_o;
      if (push_o === 1'b1) begin
         npush++;
         pushed = {pushed[7:0], stack_byte_o};
      end
      if (pop_o === 1'b1) npop <= npop + 1;
      if (int_done_o === 1'b1) idn = 1'b1;
   end

   task automatic chk(input string what, input logic [15:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic run(input logic [7:0] op, b2, b3, input int ln, mc);
      int n;
      int d;
      tgt = 16'hxxxx;
      {cv, bv, yv} = 'x;
      idn = 1'b0;
      npush = 0;
      npop = 0;
      d = (mc * MCK < 3) ? 3 : mc * MCK;
      if ((op inside {8'h12, 8'h22, 8'h32} || op[4:0] == 5'h11) && d < 5)
         d = 5;
      opcode_i <= op;
      byte2_i <= b2;
      byte3_i <= b3;
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
         if (n == 2) chk("busy", 1, busy_o);
      end while (done_o !== 1'b1 && n < 40);
      chk("done cycle", d, n - 1);
      chk("length", ln, instr_len_o);
      chk("machine cycles", mc, mc_count_o);
   endtask

   task automatic t_bool;
      logic [7:0] ops [13] = '{8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92,
         8'hc2, 8'hd2, 8'hb2, 8'hc3, 8'hd3, 8'hb3, 8'h00};
      logic c, b, ec, eb;
      foreach (ops[i]) begin
         for (int k = 0; k < 4; k++) begin
            c = k[1];
            b = k[0];
            carry_i <= c;
            bit_i <= b;
            {ec, eb} = 2'bxx;
            case (ops[i])
               8'h82: ec = c & b;
               8'hb0: ec = c & ~b;
               8'h72: ec = c | b;
               8'ha0: ec = c | ~b;
               8'ha2: ec = b;
               8'hc3: ec = 1'b0;
               8'hd3: ec = 1'b1;
               8'hb3: ec = ~c;
               8'h92: eb = c;
               8'hc2: eb = 1'b0;
               8'hd2: eb = 1'b1;
               8'hb2: eb = ~b;
               default: ;
            endcase
            run(ops[i], 8'h0b, 8'h00, (ops[i][0] || ops[i] == 8'h00) ? 1 : 2,
               ops[i] inside {8'h82, 8'hb0, 8'h72, 8'ha0, 8'h92} ? 2 : 1);
            chk("carry", ec, cv);
            chk("bit", eb, bv);
         end
      end
      run(8'ha5, 8'h00, 8'h00, 1, 1);
      chk("illegal", 1, illegal_o);
      run(8'h82, 8'h93, 8'h00, 2, 2);
      chk("illegal", 0, illegal_o);
      chk("kind", OPK_BIT, operand_kind_o);
      chk("bit byte", 8'h90, operand_addr_o);
      chk("bit sfr", 1, operand_sfr_o);
      chk("bit select", 3, bit_sel_o);
      $display("bit manipulation test done");
   endtask

   task automatic jmp(input logic [7:0] op, b2, b3, input int ln,
      input logic [15:0] t);
      logic cl;
      logic rt;
      cl = op == 8'h12 || op[4:0] == 5'h11;
      rt = op inside {8'h22, 8'h32};
      run(op, b2, b3, ln, 2);
      chk("target", t, tgt);
      chk("pushes", cl ? 2 : 0, npush);
      if (cl) chk("pushed", 16'h0088, pushed);
      chk("pops", rt ? 2 : 0, npop);
      chk("int done", op == 8'h32, idn);
   endtask

   task automatic t_jump;
      next_pc_i <= 16'h8800;
      acc_i <= 8'hff;
      data_pointer_i <= 16'hfff0;
      jmp(8'he1, 8'h5a, 8'h00, 2, 16'h8f5a);
      jmp(8'hf1, 8'h5a, 8'h00, 2, 16'h8f5a);
      jmp(8'h01, 8'h5a, 8'h00, 2, 16'h885a);
      jmp(8'h11, 8'ha5, 8'h00, 2, 16'h88a5);
      jmp(8'h02, 8'h12, 8'h34, 3, 16'h1234);
      jmp(8'h12, 8'hfe, 8'hdc, 3, 16'hfedc);
      jmp(8'h80, 8'h80, 8'h00, 2, 16'h8780);
      jmp(8'h80, 8'h7f, 8'h00, 2, 16'h887f);
      jmp(8'h73, 8'h00, 8'h00, 1, 16'h00ef);
      jmp(8'h22, 8'h00, 8'h00, 1, 16'habcd);
      jmp(8'h32, 8'h00, 8'h00, 1, 16'habcd);
      $display("jump test done");
   endtask

   task automatic br(input logic [7:0] op, b2, b3, a, opd,
      input logic c, b, tk);
      logic l3;
      l3 = op[7:4] inside {4'h1, 4'h2, 4'h3, 4'hb} || op == 8'hd5;
      acc_i <= a;
      operand_i <= opd;
      carry_i <= c;
      bit_i <= b;
      run(op, b2, b3, l3 ? 3 : 2, 2);
      chk("branch", tk ? (l3 ? 16'h017f : 16'h0080) : 16'hxxxx, tgt);
      chk("cleared bit", (op == 8'h10 && tk) ? 1'b0 : 1'bx, bv);
      chk("count", (op[7:4] == 4'hd) ? 8'(opd - 8'h01) : 8'hxx, yv);
      if (op[7:4] inside {4'h1, 4'h2, 4'h3})
         chk("bit byte", 8'h21, operand_addr_o);
      if (op[7:4] inside {4'hb, 4'hd} && op[3])
         chk("register", op[2:0], operand_addr_o);
      if (op[7:1] == 7'h5b) chk("pointer", op[0], operand_addr_o);
   endtask

   task automatic t_branch;
      next_pc_i <= 16'h0100;
      br(8'h60, 8'h80, 8'h00, 8'h00, 8'h00, 0, 0, 1);
      br(8'h60, 8'h80, 8'h00, 8'h01, 8'h00, 0, 0, 0);
      br(8'h70, 8'h80, 8'h00, 8'h01, 8'h00, 0, 0, 1);
      br(8'h70, 8'h80, 8'h00, 8'h00, 8'h00, 0, 0, 0);
      br(8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 1, 0, 1);
      br(8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 0, 1, 0);
      br(8'h50, 8'h80, 8'h00, 8'h00, 8'h00, 0, 1, 1);
      br(8'h50, 8'h80, 8'h00, 8'h00, 8'h00, 1, 0, 0);
      br(8'h20, 8'h0b, 8'h7f, 8'h00, 8'h00, 0, 1, 1);
      br(8'h20, 8'h0b, 8'h7f, 8'h00, 8'h00, 1, 0, 0);
      br(8'h30, 8'h0b, 8'h7f, 8'h00, 8'h00, 1, 0, 1);
      br(8'h30, 8'h0b, 8'h7f, 8'h00, 8'h00, 0, 1, 0);
      br(8'h10, 8'h0b, 8'h7f, 8'h00, 8'h00, 0, 1, 1);
      br(8'h10, 8'h0b, 8'h7f, 8'h00, 8'h00, 1, 0, 0);
      br(8'hb5, 8'h80, 8'h7f, 8'h05, 8'h05, 0, 0, 0);
      chk("direct sfr", 1, operand_sfr_o);
      chk("kind", OPK_DIRECT, operand_kind_o);
      br(8'hb5, 8'h7f, 8'h7f, 8'h05, 8'h06, 0, 0, 1);
      chk("direct sfr", 0, operand_sfr_o);
      br(8'hb4, 8'h05, 8'h7f, 8'h05, 8'h00, 0, 0, 0);
      br(8'hb4, 8'h04, 8'h7f, 8'h05, 8'h00, 0, 0, 1);
      br(8'hb6, 8'h07, 8'h7f, 8'h00, 8'h07, 0, 0, 0);
      br(8'hb7, 8'h07, 8'h7f, 8'h00, 8'h08, 0, 0, 1);
      br(8'hbb, 8'h00, 8'h7f, 8'h00, 8'h01, 0, 0, 1);
      br(8'hd8, 8'h80, 8'h00, 8'h00, 8'h01, 0, 0, 0);
      br(8'hdf, 8'h80, 8'h00, 8'h00, 8'h00, 0, 0, 1);
      br(8'hd5, 8'h30, 8'h7f, 8'h00, 8'h02, 0, 0, 1);
      $display("conditional branch test done");
   endtask

   initial begin
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      chk("idle busy", 0, busy_o);
      chk("reset length", 1, instr_len_o);
      t_bool();
      t_jump();
      t_branch();
      complete_run();
   end
endmodule
